/* File: pac_clk_sel.sv */
`timescale 1ns/1ps
// Picks the conversion step rate: the internal divider unless a toggling
// external clock has been seen for long enough.
module pac_clk_sel
    import pac_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic external_clock_input,
    output logic      step_en,
    output logic      ext_active
);
    typedef struct packed {
        logic [7:0]  div;
        logic        ext_d;
        logic [15:0] seen;
        logic [15:0] quiet;
        logic        ext_sel;
    } pac_cs_t;

    pac_cs_t st_r, st_nxt;
    logic    ext_rise;

    always_comb begin
        st_nxt   = st_r;
        st_nxt.ext_d = external_clock_input;
        ext_rise = external_clock_input & ~st_r.ext_d;
        st_nxt.div = (st_r.div == 8'(INT_DIV - 1)) ? 8'h00 : st_r.div + 8'h01;
        if (ext_rise) begin
            st_nxt.quiet = 16'h0000;
        end else if (st_r.quiet != 16'(EXT_LOST_CYC)) begin
            st_nxt.quiet = st_r.quiet + 16'h0001;
        end
        // Switch over only after the external clock toggled for a while
        if (st_r.quiet == 16'(EXT_LOST_CYC)) begin
            st_nxt.seen    = 16'h0000;
            st_nxt.ext_sel = 1'b0;
        end else if (st_r.seen == 16'(SWITCH_CYC)) begin
            st_nxt.ext_sel = 1'b1;
        end else begin
            st_nxt.seen = st_r.seen + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // Idle pin level is high, so no false edge follows reset,
            // and the external clock starts out counted as lost
            st_r       <= '0;
            st_r.ext_d <= 1'b1;
            st_r.quiet <= 16'(EXT_LOST_CYC);
        end else begin
            st_r <= st_nxt;
        end
    end

    // Held-high or floating pin gives no edges, so internal rate stays
    assign step_en    = st_r.ext_sel ? (external_clock_input & ~st_r.ext_d)
                                     : (st_r.div == 8'h00);
    assign ext_active = st_r.ext_sel;

    property p_ext_needs_wait;
        @(posedge clk) disable iff (reset)
        $rose(st_r.ext_sel) |-> $past(st_r.seen) == 16'(SWITCH_CYC);
    endproperty
    a_ext_needs_wait: assert property (p_ext_needs_wait)
        else $error("external clock selected too early");
endmodule : pac_clk_sel

/* File: pac_conv_port.sv */
`timescale 1ns/1ps
// What this block does
// - Read and write strobes count only while chip select is low.
// - A selected write strobe rising edge starts a conversion.
// - That edge puts the sampler in hold until the conversion ends.
// - Outside a conversion the sampler tracks.
// - Done falls only after the result is in the output latch.
// - The output latch loads when done falls and holds until the next fall.
// - The result bus is driven only while select and read are low.
// - A selected read falling edge returns done high.
// - Bus bit 0 is the LSB and bit 9 the MSB of the 10-bit result.
// - A clock on the external input times the conversion instead.
// - Switch-over to the external clock takes a few microseconds.
// - Inputs at or past the references give all ones or all zeros.
// - With the internal clock, a conversion completes within 6 us of its start.
// - Once holding, conversion proceeds with no further bus action.
module pac_conv_port
    import pac_pkg::*;
#(
    parameter int RW = RES_W
)(
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          cs_n,
    input  wire logic          wr_n,
    input  wire logic          rd_n,
    input  wire logic          external_clock_input,
    // Comparator answer: analog_input above the trial level
    input  wire logic          cmp_above,
    input  wire logic          ref_high_hit,
    input  wire logic          ref_low_hit,
    output logic [RW-1:0]      trial_code,
    output logic               sample_hold,
    output logic [RW-1:0]      result_o,
    output logic [RW-1:0]      result_oe,
    output logic               done_n,
    output logic               ext_active
);
    ////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {PAC_TRACK, PAC_CONV, PAC_LOAD} pac_state_t;

    typedef struct packed {
        pac_state_t    state;
        logic          wr_d;
        logic          rd_d;
        logic [RW-1:0] sar;
        logic [RW-1:0] bitm;
        logic [RW-1:0] latch;
        logic [RW-1:0] dout;
        logic          done_n;
        logic [15:0]   age;
    } pac_port_t;

    pac_port_t st_r, st_nxt;
    logic      step_en;
    logic      wr_rise;
    logic      rd_fall;
    logic      sel_read;

    pac_clk_sel u_clk_sel (
        .clk                  (clk),
        .reset                (reset),
        .external_clock_input (external_clock_input),
        .step_en              (step_en),
        .ext_active           (ext_active)
    );

    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt   = st_r;
        st_nxt.wr_d = wr_n;
        st_nxt.rd_d = rd_n;
        wr_rise  = ~cs_n & wr_n & ~st_r.wr_d;
        rd_fall  = ~cs_n & ~rd_n & st_r.rd_d;
        sel_read = ~cs_n & ~rd_n;
        if (rd_fall) begin
            st_nxt.done_n = 1'b1;
        end
        unique case (st_r.state)
            PAC_TRACK: begin
                st_nxt.age = 16'h0000;
            end
            PAC_CONV: begin
                st_nxt.age = st_r.age + 16'h0001;
                if (step_en) begin
                    if (cmp_above) begin
                        st_nxt.sar = st_r.sar | st_r.bitm;
                    end else begin
                        st_nxt.sar = st_r.sar & ~st_r.bitm;
                    end
                    st_nxt.bitm = st_r.bitm >> 1;
                    if (st_r.bitm[0]) begin
                        st_nxt.state = PAC_LOAD;
                    end
                end
            end
            PAC_LOAD: begin
                if (!st_r.done_n) begin
                    // Unread result: raise done for one cycle so that
                    // the new result still gets its own falling edge
                    st_nxt.done_n = 1'b1;
                end else begin
                    // Clamp at the references, then latch as done falls
                    if (ref_high_hit) begin
                        st_nxt.latch = CODE_FULL;
                    end else if (ref_low_hit) begin
                        st_nxt.latch = CODE_ZERO;
                    end else begin
                        st_nxt.latch = st_r.sar;
                    end
                    st_nxt.done_n = 1'b0;
                    st_nxt.state  = PAC_TRACK;
                end
            end
        endcase
        // A new start aborts any conversion in flight
        if (wr_rise) begin
            st_nxt.state = PAC_CONV;
            st_nxt.sar   = '0;
            st_nxt.bitm  = {1'b1, {(RW-1){1'b0}}};
            st_nxt.age   = 16'h0000;
        end
        // Data out reg follows the latch; only changes at done fall
        st_nxt.dout = st_nxt.latch;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r        <= '0;
            st_r.wr_d   <= 1'b1;
            st_r.rd_d   <= 1'b1;
            st_r.done_n <= 1'b1;
            st_r.state  <= PAC_TRACK;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Trial code: current SAR bits plus the bit under test
    assign trial_code  = st_r.sar | st_r.bitm;
    assign sample_hold = (st_r.state != PAC_TRACK);
    assign result_o    = st_r.dout;
    assign result_oe   = {RW{sel_read}};
    assign done_n      = st_r.done_n;

    ////////////////////////////////////////////////////////////////
    property p_hold_on_start;
        @(posedge clk) disable iff (reset)
        (~cs_n & wr_n & ~st_r.wr_d) |=> sample_hold;
    endproperty
    a_hold_on_start: assert property (p_hold_on_start)
        else $error("sampler not holding after start");

    property p_ignore_unselected;
        @(posedge clk) disable iff (reset)
        (cs_n && !sample_hold) |=> !sample_hold;
    endproperty
    a_ignore_unselected: assert property (p_ignore_unselected)
        else $error("conversion started without chip select");

    property p_latch_before_done;
        @(posedge clk) disable iff (reset)
        $fell(done_n) |-> $past(st_r.state) == PAC_LOAD
            && result_o == st_r.latch
            && (!sample_hold || $past(wr_rise));
    endproperty
    a_latch_before_done: assert property (p_latch_before_done)
        else $error("done fell before latch update");

    property p_latch_stable;
        @(posedge clk) disable iff (reset)
        !$fell(done_n) |-> $stable(st_r.latch);
    endproperty
    a_latch_stable: assert property (p_latch_stable)
        else $error("output latch changed without done falling");

    property p_bus_drive;
        @(posedge clk) disable iff (reset)
        (result_oe != '0) == (!cs_n && !rd_n);
    endproperty
    a_bus_drive: assert property (p_bus_drive)
        else $error("bus drive outside a selected read");

    property p_read_clears_done;
        @(posedge clk) disable iff (reset)
        // A completion in the same cycle wins over the read
        (!cs_n && !rd_n && st_r.rd_d && st_r.state != PAC_LOAD) |=> done_n;
    endproperty
    a_read_clears_done: assert property (p_read_clears_done)
        else $error("done not cleared by read");

    property p_conv_time;
        @(posedge clk) disable iff (reset)
        ext_active == 1'b0 |-> st_r.age <= 16'(CONV_MAX_CYC);
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion exceeded its time limit");

    property p_track_idle;
        @(posedge clk) disable iff (reset)
        $fell(sample_hold) |-> $past(st_r.state) == PAC_LOAD;
    endproperty
    a_track_idle: assert property (p_track_idle)
        else $error("sampler released without finishing");

    property p_done_stands;
        @(posedge clk) disable iff (reset)
        (!done_n && !rd_fall && st_r.state != PAC_LOAD) |=> !done_n;
    endproperty
    a_done_stands: assert property (p_done_stands)
        else $error("done returned high without a read");

    property p_track_until_start;
        @(posedge clk) disable iff (reset)
        (!sample_hold && !wr_rise) |=> !sample_hold;
    endproperty
    a_track_until_start: assert property (p_track_until_start)
        else $error("sampler held without a start");

    property p_step_only_on_enable;
        @(posedge clk) disable iff (reset)
        (st_r.state == PAC_CONV && !step_en && !wr_rise)
            |=> $stable(st_r.sar) && $stable(st_r.bitm);
    endproperty
    a_step_only_on_enable: assert property (p_step_only_on_enable)
        else $error("approximation stepped without a step enable");

    property p_clamp_high;
        @(posedge clk) disable iff (reset)
        (st_r.state == PAC_LOAD && st_r.done_n && ref_high_hit)
            |=> result_o == CODE_FULL;
    endproperty
    a_clamp_high: assert property (p_clamp_high)
        else $error("input above the high reference not clamped");
endmodule : pac_conv_port

/* File: pac_host_model.sv */
`timescale 1ns/1ps
module pac_host_model
    import pac_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [RES_W-1:0] bus,
    output logic                  cs_n,
    output logic                  wr_n,
    output logic                  rd_n
);
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
    end
    // Select stays low over the strobe edge; sel 0 sends a stray strobe
    task automatic start(input logic sel);
        @(posedge clk);
        cs_n <= !sel;
        wr_n <= 1'b0;
        @(posedge clk);
        wr_n <= 1'b1;
        @(posedge clk);
        cs_n <= 1'b1;
    endtask : start
    task automatic read(input logic sel, output logic [RES_W-1:0] d);
        @(posedge clk);
        cs_n <= !sel;
        rd_n <= 1'b0;
        repeat (2) @(posedge clk);
        d = bus;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask : read
endmodule : pac_host_model

/* File: pac_pkg.sv */
package pac_pkg;
    localparam int RES_W        = 10;
    localparam int CLK_HZ       = 50_000_000;
    localparam int CLK_NS       = 20;
    // Longest conversion time in ns, with the cycles it allows
    localparam int CONV_MAX_NS  = 6000;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
    // SAR steps: one per bit, none for the latch transfer
    localparam int SAR_STEPS    = RES_W;
    // Switch-over to the external clock: a few microseconds
    localparam int SWITCH_NS    = 4000;
    localparam int SWITCH_CYC   = SWITCH_NS / CLK_NS;
    // Internal conversion clock divider at 50 MHz
    localparam int INT_DIV      = 12;
    // External clock counted as lost after this many quiet cycles
    localparam int EXT_LOST_CYC = 200;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] CODE_FULL = 10'h3ff;
endpackage : pac_pkg

/* File: parallel_adc_conversion_port_bench.sv */
`timescale 1ns/1ps
module parallel_adc_conversion_port_bench;
    import pac_pkg::*;
    typedef struct packed {
        logic [9:0] a;
        logic       hi;
        logic       lo;
        logic [9:0] e;
    } pac_row_t;
    logic             clk, reset, ext_clk, ext_run, hi_hit, lo_hit;
    logic [2:0]       ext_div;
    logic [RES_W-1:0] analog_input, d;
    wire  [RES_W-1:0] trial, res_o, res_oe, bus;
    wire              cs_n, wr_n, rd_n, cmp_above, hold, done_n, ext_act;
    int               bad_count, n_compared;
    pac_row_t rows [5] = '{
        '{10'h005, 1'b0, 1'b1, CODE_ZERO},
        '{10'h3f0, 1'b1, 1'b0, CODE_FULL},
        '{10'h200, 1'b0, 1'b0, 10'h200},
        '{10'h1ff, 1'b0, 1'b0, 10'h1ff},
        '{10'h2a5, 1'b0, 1'b0, 10'h2a5}};
    pac_conv_port i_pac_conv_port (.clk(clk), .reset(reset), .cs_n(cs_n),
        .wr_n(wr_n), .rd_n(rd_n), .external_clock_input(ext_clk),
        .cmp_above(cmp_above), .ref_high_hit(hi_hit), .ref_low_hit(lo_hit),
        .trial_code(trial), .sample_hold(hold), .result_o(res_o),
        .result_oe(res_oe), .done_n(done_n), .ext_active(ext_act));
    pac_host_model i_pac_host_model (.clk(clk), .bus(bus), .cs_n(cs_n),
        .wr_n(wr_n), .rd_n(rd_n));
    for (genvar i = 0; i < RES_W; i++) begin : g_bus
        assign bus[i] = res_oe[i] ? res_o[i] : 1'bz;
    end
    // Ideal comparator: input sits half a step above its code
    assign cmp_above = (trial <= analog_input);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // 6.25 MHz external clock; held high when unused
    always @(posedge clk) begin
        ext_div <= reset ? 3'h0 : ext_div + 3'h1;
        ext_clk <= ext_run ? ext_div[2] : 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_code
    task automatic chk_bit(input logic got, input logic exp);
        chk_code({9'h0, got}, {9'h0, exp});
    endtask : chk_bit
    task automatic conv_start();
        i_pac_host_model.start(1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk_bit(hold, 1'b1);
    endtask : conv_start
    task automatic wait_done(input logic lvl);
        int cyc;
        cyc = 0;
        // Done polled with a bound of the longest conversion
        while (done_n !== lvl && cyc < CONV_MAX_CYC) begin
            @(posedge clk);
            #1;
            cyc++;
        end
    endtask : wait_done
    task automatic finish(input logic [9:0] e);
        wait_done(1'b0);
        chk_bit(done_n, 1'b0);
        chk_bit(hold, 1'b0);
        chk_code(res_o, e);
        i_pac_host_model.read(1'b0, d);
        #1;
        chk_code(d, 10'hzzz);
        chk_bit(done_n, 1'b0);
        i_pac_host_model.read(1'b1, d);
        #1;
        chk_code(d, e);
        chk_bit(done_n, 1'b1);
        chk_code(res_oe, 10'h000);
    endtask : finish
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial begin
        {reset, ext_run, hi_hit, lo_hit} = 4'h8;
        {analog_input, bad_count, n_compared} = '0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk_bit(done_n, 1'b1);
        chk_bit(hold, 1'b0);
        $display("reset test done");
        foreach (rows[k]) begin
            @(posedge clk);
            {analog_input, hi_hit, lo_hit} <= {rows[k].a, rows[k].hi, rows[k].lo};
            conv_start();
            finish(rows[k].e);
            $display("row %0d done", k);
        end
        i_pac_host_model.start(1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk_bit(hold, 1'b0);
        $display("stray strobe done");
        analog_input <= 10'h0f0;
        conv_start();
        i_pac_host_model.read(1'b1, d);
        chk_code(d, rows[4].e);
        finish(10'h0f0);
        $display("stale read done");
        ext_run <= 1'b1;
        // Switch-over must not be immediate
        repeat (100) @(posedge clk);
        #1;
        chk_bit(ext_act, 1'b0);
        repeat (200) @(posedge clk);
        #1;
        chk_bit(ext_act, 1'b1);
        analog_input <= 10'h333;
        conv_start();
        finish(10'h333);
        ext_run <= 1'b0;
        repeat (300) @(posedge clk);
        #1;
        chk_bit(ext_act, 1'b0);
        $display("external clock done");
        // Second result while the first is still unread
        @(posedge clk);
        analog_input <= 10'h0aa;
        conv_start();
        wait_done(1'b0);
        chk_bit(done_n, 1'b0);
        chk_code(res_o, 10'h0aa);
        @(posedge clk);
        analog_input <= 10'h355;
        conv_start();
        chk_bit(done_n, 1'b0);
        wait_done(1'b1);
        chk_bit(done_n, 1'b1);
        chk_code(res_o, 10'h0aa);
        finish(10'h355);
        $display("unread result done");
        // Reset in the middle of a conversion
        @(posedge clk);
        analog_input <= 10'h155;
        conv_start();
        repeat (20) @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk_bit(hold, 1'b0);
        chk_bit(done_n, 1'b1);
        chk_code(res_o, CODE_ZERO);
        conv_start();
        finish(10'h155);
        $display("mid-run reset done");
        test_done();
    end
endmodule : parallel_adc_conversion_port_bench
